//--- shared/epi_pkg.sv
/*
  Package of the external parallel interface sequencer: register map,
  field layout, reset values, state encoding and timing figures.
  Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
*/
`default_nettype none
package epi_pkg;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned AXI_AW = 8;
  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_TIMING = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_ADDR = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_WDATA = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_CMD = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_RDATA = 8'h14;
  // Timing register fields
  localparam int unsigned F_RD_LEAD = 0;
  localparam int unsigned F_RD_ACT = 4;
  localparam int unsigned F_RD_TRAIL = 8;
  localparam int unsigned F_WR_LEAD = 12;
  localparam int unsigned F_WR_ACT = 16;
  localparam int unsigned F_WR_TRAIL = 20;
  localparam int unsigned F_RDY_EN = 24;
  localparam int unsigned F_RDY_STYLE = 25;
  localparam int unsigned F_DOUBLING = 26;
  localparam int unsigned TIMING_W = 27;
  localparam logic [31:0] TIMING_RST = 32'h00111111;
  // Command and status bits
  localparam int unsigned F_CMD_WRITE = 0;
  localparam int unsigned F_ST_BUSY = 0;
  localparam int unsigned F_ST_DONE = 1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    EPI_IDLE,
    EPI_ALIGN,
    EPI_LEAD,
    EPI_ACTIVE,
    EPI_WAIT,
    EPI_TRAIL
  } epi_state_t;
endpackage : epi_pkg
`default_nettype wire

//--- hdl/epi_sync2.sv
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the input may change at any time relative to clk_i.
*/
`default_nettype none
module epi_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = ce_i ? d_i : meta_ff;
    nxt_sync = ce_i ? meta_ff : sync_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q_o = sync_ff;
endmodule : epi_sync2
`default_nettype wire

//--- hdl/epi_seq.sv
/*
  External parallel interface sequencer: AXI4-Lite register slave and the
  lead/active/trail state machine driving zone select, strobes, direction,
  address and a three-signal data bus. One clock is one timing-clock cycle.
  Assumes the external ready pin is asynchronous to mclk_i.
*/
// Notes on behaviour
// - Each access lead starts on a rising bus clock edge, else one alignment cycle.
// - Alignment cycles hold every strobe and control inactive.
// - With ready sampling off, external ready is ignored entirely.
// - Address bus keeps the last driven address while inactive.
// - Synchronous ready first sampled lead plus active cycles after start.
// - Ready found high ends the wait and the access completes.
// - Ready low is sampled again each cycle; partner holds it low.
// - Write data drive starts no earlier than write strobe assertion.
// - Write data held through trail; released when direction returns high.
// - Periods counted in timing clocks; bus clock same or half rate (with doubling off, bus_clock_out_o is held high).
// - Select, direction at start; strobe on at active, off at trail; select off at end.
// - Half-rate bus clock: even count rising edge, odd count falling.
`default_nettype none
module epi_seq
  import epi_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_ready_in_i,
  output logic bus_clock_out_o,
  output logic zone_select_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic direction_signal_o,
  output logic [ADDR_W-1:0] ext_address_bus_o,
  input wire logic [DATA_W-1:0] ext_data_bus_i,
  output logic [DATA_W-1:0] ext_data_bus_o,
  output logic ext_data_bus_oe_o
);
  logic [TIMING_W-1:0] timing_ff, nxt_timing;
  logic [ADDR_W-1:0] addr_reg_ff, nxt_addr_reg;
  logic [DATA_W-1:0] wdata_reg_ff, nxt_wdata_reg;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic start_ff, nxt_start;
  logic is_wr_ff, nxt_is_wr;
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, ar_ff, nxt_ar, rv_ff, nxt_rv;
  logic [AXI_AW-1:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  epi_state_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0] elapsed_ff, nxt_elapsed;
  logic phase_ff, nxt_phase;
  logic bclk_ff, nxt_bclk;
  logic zcs_ff, nxt_zcs, rd_n_ff, nxt_rd_n, we_n_ff, nxt_we_n, dir_ff, nxt_dir;
  logic [ADDR_W-1:0] xa_ff, nxt_xa;
  logic [DATA_W-1:0] xd_ff, nxt_xd;
  logic oe_ff, nxt_oe;
  logic rdy_sync;
  logic busy;
  logic [CNT_W-1:0] lead, act, trail;

  epi_sync2 u_rdy_sync (
    .clk_i(mclk_i),
    .rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i(external_ready_in_i),
    .q_o(rdy_sync)
  );

  assign busy = (st_ff != EPI_IDLE) || start_ff;
  assign lead = is_wr_ff ? timing_ff[F_WR_LEAD +: CNT_W] : timing_ff[F_RD_LEAD +: CNT_W];
  assign act = is_wr_ff ? timing_ff[F_WR_ACT +: CNT_W] : timing_ff[F_RD_ACT +: CNT_W];
  assign trail = is_wr_ff ? timing_ff[F_WR_TRAIL +: CNT_W] : timing_ff[F_RD_TRAIL +: CNT_W];

  // AXI4-Lite slave
  always_comb begin
    logic do_wr;
    do_wr = 1'b0;
    nxt_aw = aw_ff;
    nxt_awa = awa_ff;
    nxt_w = w_ff;
    nxt_wd = wd_ff;
    nxt_bv = bv_ff;
    nxt_bresp = bresp_ff;
    nxt_ar = ar_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rresp = rresp_ff;
    nxt_timing = timing_ff;
    nxt_addr_reg = addr_reg_ff;
    nxt_wdata_reg = wdata_reg_ff;
    nxt_start = start_ff;
    nxt_is_wr = is_wr_ff;
    nxt_done = done_ff;
    if (s_axi_awvalid && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff && !bv_ff) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
    end
    if (aw_ff && w_ff && !bv_ff) begin
      do_wr = 1'b1;
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_bresp = RESP_OKAY;
      unique case (awa_ff)
        OFS_TIMING: nxt_timing = wd_ff[TIMING_W-1:0];
        OFS_ADDR: nxt_addr_reg = wd_ff[ADDR_W-1:0];
        OFS_WDATA: nxt_wdata_reg = wd_ff[DATA_W-1:0];
        OFS_CMD: begin
          if (!busy) begin
            nxt_start = 1'b1;
            nxt_is_wr = wd_ff[F_CMD_WRITE];
            nxt_done = 1'b0;
          end
        end
        OFS_STATUS, OFS_RDATA: ;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    if (s_axi_arvalid && !ar_ff && !rv_ff) begin
      nxt_ar = 1'b1;
      nxt_rv = 1'b1;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_TIMING: nxt_rd = 32'(timing_ff);
        OFS_ADDR: nxt_rd = 32'(addr_reg_ff);
        OFS_WDATA: nxt_rd = 32'(wdata_reg_ff);
        OFS_CMD: nxt_rd = 32'(is_wr_ff);
        OFS_STATUS: nxt_rd = 32'({done_ff, busy});
        OFS_RDATA: nxt_rd = 32'(rdata_ff);
        default: begin
          nxt_rd = 32'h00000000;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end else begin
      nxt_ar = 1'b0;
      if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
    end
    if (st_ff != EPI_IDLE) nxt_start = 1'b0;
    // Completion sets done over any same-cycle clear
    if (st_ff == EPI_TRAIL && nxt_st == EPI_IDLE) nxt_done = 1'b1;
    if (do_wr && awa_ff == OFS_CMD && busy) nxt_bresp = RESP_SLVERR;
  end

  // Access sequencer
  always_comb begin
    logic doubling;
    logic wait_rdy;
    doubling = timing_ff[F_DOUBLING];
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_elapsed = elapsed_ff;
    nxt_rdata = rdata_ff;
    nxt_zcs = zcs_ff;
    nxt_rd_n = rd_n_ff;
    nxt_we_n = we_n_ff;
    nxt_dir = dir_ff;
    nxt_xa = xa_ff;
    nxt_xd = xd_ff;
    nxt_oe = oe_ff;
    // half-rate bus clock toggles on each timing clock
    nxt_phase = doubling ? ~phase_ff : 1'b0;
    nxt_bclk = doubling ? ~phase_ff : 1'b1;
    // ready only consulted when sampling enabled
    wait_rdy = timing_ff[F_RDY_EN] && !rdy_sync;
    unique case (st_ff)
      EPI_IDLE: begin
        if (start_ff) begin
          // start on rising bus clock edge, else align
          if (doubling && phase_ff) begin
            nxt_st = EPI_ALIGN;
          end else begin
            nxt_st = EPI_LEAD;
            nxt_cnt = lead;
            nxt_elapsed = 8'h00;
            // select and direction at access start
            nxt_zcs = 1'b0;
            nxt_dir = !is_wr_ff;
            nxt_xa = addr_reg_ff;
          end
        end
      end
      EPI_ALIGN: begin
        nxt_st = EPI_LEAD;
        nxt_cnt = lead;
        nxt_elapsed = 8'h00;
        nxt_zcs = 1'b0;
        nxt_dir = !is_wr_ff;
        nxt_xa = addr_reg_ff;
      end
      EPI_LEAD: begin
        nxt_elapsed = elapsed_ff + 8'h01;
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_st = EPI_ACTIVE;
          nxt_cnt = act;
          // strobe at active start; parity follows elapsed count
          nxt_rd_n = is_wr_ff;
          nxt_we_n = !is_wr_ff;
          // data driven with the write strobe
          nxt_oe = is_wr_ff;
          nxt_xd = wdata_reg_ff;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      EPI_ACTIVE, EPI_WAIT: begin
        nxt_elapsed = elapsed_ff + 8'h01;
        if (st_ff == EPI_ACTIVE && cnt_ff > CNT_W'(1)) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        // first sample at lead plus active, then every cycle; strobe held
        end else if (wait_rdy) begin
          nxt_st = EPI_WAIT;
        end else begin
          // ready high ends the wait; capture read data
          if (!is_wr_ff) nxt_rdata = ext_data_bus_i;
          nxt_rd_n = 1'b1;
          nxt_we_n = 1'b1;
          nxt_st = EPI_TRAIL;
          nxt_cnt = trail;
        end
      end
      EPI_TRAIL: begin
        nxt_elapsed = elapsed_ff + 8'h01;
        if (cnt_ff <= CNT_W'(1)) begin
          nxt_st = EPI_IDLE;
          nxt_zcs = 1'b1;
          nxt_dir = 1'b1;
          // data held through trail, released with direction
          nxt_oe = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      default: nxt_st = EPI_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      timing_ff <= TIMING_RST[TIMING_W-1:0];
      addr_reg_ff <= '0;
      wdata_reg_ff <= '0;
      rdata_ff <= '0;
      done_ff <= 1'b0;
      start_ff <= 1'b0;
      is_wr_ff <= 1'b0;
      aw_ff <= 1'b0;
      awa_ff <= '0;
      w_ff <= 1'b0;
      wd_ff <= 32'h00000000;
      bv_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      ar_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
      st_ff <= EPI_IDLE;
      cnt_ff <= '0;
      elapsed_ff <= 8'h00;
      phase_ff <= 1'b0;
      bclk_ff <= 1'b1;
      zcs_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      dir_ff <= 1'b1;
      xa_ff <= '0;
      xd_ff <= '0;
      oe_ff <= 1'b0;
    end else if (ce_i) begin
      timing_ff <= nxt_timing;
      addr_reg_ff <= nxt_addr_reg;
      wdata_reg_ff <= nxt_wdata_reg;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
      start_ff <= nxt_start;
      is_wr_ff <= nxt_is_wr;
      aw_ff <= nxt_aw;
      awa_ff <= nxt_awa;
      w_ff <= nxt_w;
      wd_ff <= nxt_wd;
      bv_ff <= nxt_bv;
      bresp_ff <= nxt_bresp;
      ar_ff <= nxt_ar;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rresp_ff <= nxt_rresp;
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      elapsed_ff <= nxt_elapsed;
      phase_ff <= nxt_phase;
      bclk_ff <= nxt_bclk;
      zcs_ff <= nxt_zcs;
      rd_n_ff <= nxt_rd_n;
      we_n_ff <= nxt_we_n;
      dir_ff <= nxt_dir;
      xa_ff <= nxt_xa;
      xd_ff <= nxt_xd;
      oe_ff <= nxt_oe;
    end
  end

  assign s_axi_awready = aw_ff;
  assign s_axi_wready = w_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ar_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rresp_ff;
  assign bus_clock_out_o = bclk_ff;
  assign zone_select_n_o = zcs_ff;
  assign read_strobe_n_o = rd_n_ff;
  assign write_strobe_n_o = we_n_ff;
  assign direction_signal_o = dir_ff;
  assign ext_address_bus_o = xa_ff;
  assign ext_data_bus_o = xd_ff;
  assign ext_data_bus_oe_o = oe_ff;

  align_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff == EPI_ALIGN |-> zcs_ff && rd_n_ff && we_n_ff && dir_ff)
    else $error("control active in alignment");
  addr_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && zcs_ff && $past(zcs_ff) |-> $stable(ext_address_bus_o))
    else $error("address changed while idle");
  // data drive starts only with write strobe
  wr_drive_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(oe_ff) |-> !we_n_ff)
    else $error("data driven before write strobe");
  wr_release_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    oe_ff |-> !dir_ff)
    else $error("data driven with direction high");
  wait_strobe_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    st_ff == EPI_WAIT |-> !(rd_n_ff && we_n_ff))
    else $error("strobe dropped during wait");
  no_wait_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !timing_ff[F_RDY_EN] && st_ff == EPI_ACTIVE |=> st_ff != EPI_WAIT)
    else $error("wait without ready sampling");
  rdy_exit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && st_ff == EPI_WAIT && rdy_sync |=> st_ff == EPI_TRAIL)
    else $error("ready high did not end wait");
  strobe_in_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !(rd_n_ff && we_n_ff) |-> !zcs_ff)
    else $error("strobe outside zone select");
  // strobe edge parity at half rate
  strobe_phase_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    timing_ff[F_DOUBLING] && st_ff == EPI_ACTIVE && $past(st_ff) == EPI_LEAD
      |-> bclk_ff == !elapsed_ff[0])
    else $error("strobe edge off bus clock phase");
  rd_cov: cover property (@(posedge mclk_i) $rose(rd_n_ff));
  wr_cov: cover property (@(posedge mclk_i) $rose(we_n_ff));
  wait_cov: cover property (@(posedge mclk_i) st_ff == EPI_WAIT);
  align_cov: cover property (@(posedge mclk_i) st_ff == EPI_ALIGN);
endmodule : epi_seq
`default_nettype wire

//--- verification/epi_mem_model.sv
/*
  Behavioural external memory facing the parallel interface sequencer.
  Assumes the bench resolves the data bus and sets the ready stall count.
*/
`default_nettype none
module epi_mem_model
  import epi_pkg::*;
(
  input wire logic mclk_i,
  input wire logic zone_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_oe_i,
  input wire logic [3:0] stall_i,
  output logic ready_o,
  output logic [DATA_W-1:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [16];
  logic [3:0] low_cnt;
  initial begin
    ready_o = 1'b1;
    rd_data_o = 16'h0000;
    low_cnt = 4'h0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(posedge mclk_i) begin
    if (read_strobe_n_i && write_strobe_n_i) low_cnt = 4'h0;
    else if (low_cnt != 4'hF) low_cnt = low_cnt + 4'h1;
    #37 ready_o = (low_cnt >= stall_i);
  end
  always @(negedge mclk_i) begin
    if (!zone_select_n_i && !read_strobe_n_i) rd_data_o = mem[addr_i[3:0]];
    else rd_data_o = ~rd_data_o;
  end
  // Undriven bus stores garbage
  always @(posedge write_strobe_n_i) begin
    #1 mem[addr_i[3:0]] = wr_oe_i ? wr_data_i : ~wr_data_i;
  end
endmodule : epi_mem_model
`default_nettype wire

//--- verification/epi_seq_test.sv
/*
  Self-checking bench of the sequencer: AXI4-Lite master tasks, random
  accesses against the memory model, strobe length and bus release checks.
  Assumes the design's own assertions guard the cycle-level rules.
*/
`default_nettype none
module epi_seq_test;
  timeunit 1ns;
  timeprecision 1ns;
  import epi_pkg::*;
  logic mclk_i, sys_rst_i, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic rdy, bclk, zs_n, rs_n, ws_n, dir, oe, oe_seen, zs_seen;
  logic [18:0] addr;
  logic [15:0] dout, mdat, bus;
  logic [3:0] stall;
  logic [15:0] shadow [16];
  int n_mismatch, total_checks, low_run, last_run;
  assign bus = oe ? dout : mdat;
  epi_seq dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .external_ready_in_i(rdy), .bus_clock_out_o(bclk),
    .zone_select_n_o(zs_n), .read_strobe_n_o(rs_n), .write_strobe_n_o(ws_n),
    .direction_signal_o(dir), .ext_address_bus_o(addr), .ext_data_bus_i(bus),
    .ext_data_bus_o(dout), .ext_data_bus_oe_o(oe));
  epi_mem_model mem (.mclk_i(mclk_i), .zone_select_n_i(zs_n), .read_strobe_n_i(rs_n),
    .write_strobe_n_i(ws_n), .addr_i(addr), .wr_data_i(dout), .wr_oe_i(oe),
    .stall_i(stall), .ready_o(rdy), .rd_data_o(mdat));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic timeout();
    n_mismatch++;
    finish_test();
  endtask : timeout
  // Strobe run length and drive start
  always @(posedge mclk_i) begin
    if (rs_n === 1'b0 || ws_n === 1'b0) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_run <= low_run;
      low_run <= 0;
    end
    if (oe === 1'b1 && !oe_seen) check("drive start", ws_n, 1'b0);
    oe_seen <= (oe === 1'b1);
    // lead opens on bus clock high
    if (zs_n === 1'b0 && zs_seen) check("lead on rise", bclk, 1'b1);
    zs_seen <= (zs_n === 1'b1);
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit b;
    @(posedge mclk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    b = 1'b0;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge mclk_i);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) begin
        b = 1'b1;
        r = br;
        bre <= 1'b0;
      end
    end
    if (!b) timeout();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit b;
    @(posedge mclk_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    b = 1'b0;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge mclk_i);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) begin
        b = 1'b1;
        d = rd;
        r = rr;
        rre <= 1'b0;
      end
    end
    if (!b) timeout();
  endtask : axi_rd
  function automatic int eff(input logic [3:0] c);
    return (c == 4'h0) ? 1 : int'(c);
  endfunction : eff
  // Ready seen three cycles late; model raises it after s strobe cycles
  function automatic int exp_run(input logic [3:0] c, input logic [3:0] s);
    return (s == 4'h0 || eff(c) > int'(s) + 3) ? eff(c) : int'(s) + 3;
  endfunction : exp_run
  task automatic wait_done();
    logic [31:0] st;
    logic [1:0] r;
    st = 32'h00000000;
    for (int n = 0; n < 100 && st[F_ST_DONE] !== 1'b1; n++) axi_rd(OFS_STATUS, st, r);
    if (st[F_ST_DONE] !== 1'b1) timeout();
  endtask : wait_done
  task automatic access(input logic w, input logic [18:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(OFS_ADDR, {13'h0000, a}, r);
    axi_wr(OFS_WDATA, {16'h0000, d}, r);
    axi_wr(OFS_CMD, {31'h00000000, w}, r);
    check("cmd resp", r, RESP_OKAY);
    wait_done();
  endtask : access
  initial begin
    logic [31:0] tv, v;
    logic [1:0] r;
    logic [18:0] a;
    logic [15:0] d;
    logic en, w;
    {awv, wv, bre, arv, rre} = 5'h00;
    {awa, ara, wd, stall} = 52'h0;
    sys_rst_i = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    low_run = 0;
    last_run = 0;
    oe_seen = 1'b0;
    zs_seen = 1'b0;
    foreach (shadow[i]) shadow[i] = 16'h0000;
    void'($urandom(32'h4999));
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    axi_rd(OFS_TIMING, v, r);
    check("timing reset", v, TIMING_RST);
    check("idle select", {zs_n, rs_n, ws_n, dir, oe}, 5'h1E);
    axi_rd(8'h20, v, r);
    check("unmapped rd", {r, v}, {RESP_SLVERR, 32'h00000000});
    axi_wr(8'h24, 32'h0000FFFF, r);
    check("unmapped wr", r, RESP_SLVERR);
    for (int i = 0; i < 16; i++) begin
      tv = $urandom & 32'h07333333;
      en = tv[F_RDY_EN];
      if (en) tv = tv | 32'h00111111;
      stall <= 4'($urandom_range(4));
      axi_wr(OFS_TIMING, tv, r);
      axi_rd(OFS_TIMING, v, r);
      check("timing rb", v, tv);
      a = 19'($urandom);
      d = 16'($urandom);
      for (int k = 0; k < 2; k++) begin
        w = (k == 0);
        access(w, a, d);
        if (w) shadow[a[3:0]] = d;
        if (!en) check("strobe run", last_run, eff(tv[(w ? F_WR_ACT : F_RD_ACT) +: 4]));
        else check("wait run", last_run, exp_run(tv[(w ? F_WR_ACT : F_RD_ACT) +: 4], stall));
        check("addr hold", addr, a);
        check("released", {zs_n, dir, oe}, 3'h6);
      end
      axi_rd(OFS_RDATA, v, r);
      check("read data", v, {16'h0000, shadow[a[3:0]]});
    end
    axi_wr(OFS_TIMING, 32'h00FFFFFF, r);
    axi_wr(OFS_CMD, 32'h00000000, r);
    axi_rd(OFS_STATUS, v, r);
    check("busy", v[F_ST_BUSY], 1'b1);
    axi_wr(OFS_CMD, 32'h00000001, r);
    check("busy cmd", r, RESP_SLVERR);
    wait_done();
    check("long run", last_run, 15);
    finish_test();
  end
endmodule : epi_seq_test
`default_nettype wire
